// ===== rtl/acrp_pkg.sv
// shared constants and types for the converter control and readout port
package acrp_pkg;
    localparam int CLK_PERIOD_NS = 5;
    localparam int RESULT_W = 16;
    // conversion busy-low time, in ns
    localparam int BUSY_LOW_NS = 3500;
    localparam int BUSY_LOW_CYC = BUSY_LOW_NS / CLK_PERIOD_NS;
    // data valid before busy rises, least, in ns
    localparam int DATA_LEAD_NS = 25;
    localparam int DATA_LEAD_CYC = (DATA_LEAD_NS + CLK_PERIOD_NS - 1)
        / CLK_PERIOD_NS;
    // window after busy rises before a back-to-back start, in ns
    localparam int RESTART_NS = 250;
    localparam int RESTART_CYC = RESTART_NS / CLK_PERIOD_NS;
    // controller side timing, in ns
    localparam int RC_SETUP_NS = 100;
    localparam int RC_SETUP_CYC = (RC_SETUP_NS + CLK_PERIOD_NS - 1)
        / CLK_PERIOD_NS;
    localparam int RELEASE_NS = 200;
    localparam int RELEASE_CYC = RELEASE_NS / CLK_PERIOD_NS;
    localparam int SPACING_NS = 4000;
    localparam int SPACING_CYC = (SPACING_NS + CLK_PERIOD_NS - 1)
        / CLK_PERIOD_NS;
    localparam int CNT_W = 12;
    localparam logic [RESULT_W-1:0] CODE_POS_FULL = 16'h7fff;
    localparam logic [RESULT_W-1:0] CODE_MID = 16'h0000;
    localparam logic [RESULT_W-1:0] CODE_NEG_FULL = 16'h8000;
    localparam logic [RESULT_W-1:0] RESET_RESULT = 16'h0000;
    typedef enum logic [1:0]
    {
        ADC_IDLE = 2'b00,
        ADC_CONV = 2'b01,
        ADC_GUARD = 2'b10
    } acrp_adc_state_type;
    typedef enum logic [2:0]
    {
        CTL_IDLE = 3'b000,
        CTL_SETUP = 3'b001,
        CTL_START = 3'b010,
        CTL_WAIT = 3'b011,
        CTL_SPACE = 3'b100
    } acrp_ctl_state_type;
endpackage

// ===== rtl/acrp_if.sv
// pin-level link between converter and its controller
`timescale 1ns/1ps
`default_nettype none
interface acrp_if;
    logic select_n;
    logic read_conv;
    logic busy_n;
    logic [15:0] data_o;
    logic [15:0] data_oe;
    logic [15:0] data_bus;
    // resolved bus level, high impedance modelled as zero
    assign data_bus = data_o & data_oe;
    modport adc
    (
        input select_n,
        input read_conv,
        output busy_n,
        output data_o,
        output data_oe
    );
    modport ctl
    (
        output select_n,
        output read_conv,
        input busy_n,
        input data_bus
    );
endinterface
`default_nettype wire

// ===== rtl/acrp_adc.sv
// converter end: conversion control, busy and tri-state result bus
`timescale 1ns/1ps
`default_nettype none
module acrp_adc
    import acrp_pkg::*;
(
    input wire logic core_clk, // system clock
    input wire logic resetn, // async reset, active low
    acrp_if.adc link, // pins toward the controller
    input wire logic [acrp_pkg::RESULT_W-1:0] sample_in, // signed code in
    output logic hold_r, // sample-and-hold in hold
    output logic twos_complement_format // output coding flag
);
    import acrp_pkg::*;

    // synchronised pin copies and their last values
    logic [1:0] sel_sync_r;
    logic [1:0] rc_sync_r;
    logic sel_prev_r;
    logic rc_prev_r;
    // sequencer and bus state
    acrp_adc_state_type state_r;
    logic [CNT_W-1:0] cnt_r;
    logic [RESULT_W-1:0] result_r;
    logic busy_n_r;
    logic oe_r;
    logic sel_fall;
    logic rc_fall;
    logic start_req;
    logic lines_low;
    logic restart_now;
    logic conv_begin;
    logic fmt_r;

    // both synchronised lines low: convert mode, converter selected
    function automatic logic conv_asked(input logic sel_n, input logic rc);
        return !sel_n && !rc;
    endfunction

    // pin synchronisers; the lines come from another chip
    // edge detectors rest at the idle level, so reset gives no false edge
    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            sel_sync_r <= 2'b11;
            rc_sync_r <= 2'b11;
            sel_prev_r <= 1'b1;
            rc_prev_r <= 1'b1;
        end
        else
        begin
            sel_sync_r <= {sel_sync_r[0], link.select_n};
            rc_sync_r <= {rc_sync_r[0], link.read_conv};
            sel_prev_r <= sel_sync_r[1];
            rc_prev_r <= rc_sync_r[1];
        end
    end

    // one-cycle pulses on falling pin edges
    assign sel_fall = sel_prev_r && !sel_sync_r[1];
    assign rc_fall = rc_prev_r && !rc_sync_r[1];
    assign lines_low = conv_asked(sel_sync_r[1], rc_sync_r[1]);
    assign start_req = lines_low && (sel_fall || rc_fall);
    // lines still low when the guard window runs out
    assign restart_now = state_r == ADC_GUARD && cnt_r == '0 && lines_low;
    // a conversion begins on this edge; start edges inside one are dropped
    assign conv_begin = (state_r != ADC_CONV && start_req) || restart_now;

    // conversion sequencer; guard is the restart window after busy rises
    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            state_r <= ADC_IDLE;
            cnt_r <= '0;
        end
        else
        begin
            case (state_r)
                ADC_IDLE:
                begin
                    if (start_req)
                    begin
                        state_r <= ADC_CONV;
                        cnt_r <= CNT_W'(BUSY_LOW_CYC - 1);
                    end
                end
                ADC_CONV:
                begin
                    if (cnt_r == '0)
                    begin
                        state_r <= ADC_GUARD;
                        cnt_r <= CNT_W'(RESTART_CYC - 1);
                    end
                    else
                        cnt_r <= cnt_r - 1'b1;
                end
                ADC_GUARD:
                begin
                    // lines must rise in the window or a conversion follows
                    if (start_req)
                    begin
                        state_r <= ADC_CONV;
                        cnt_r <= CNT_W'(BUSY_LOW_CYC - 1);
                    end
                    else if (cnt_r == '0)
                    begin
                        state_r <= ADC_IDLE;
                        if (lines_low)
                        begin
                            state_r <= ADC_CONV;
                            cnt_r <= CNT_W'(BUSY_LOW_CYC - 1);
                        end
                    end
                    else
                        cnt_r <= cnt_r - 1'b1;
                end
                default:
                    state_r <= ADC_IDLE;
            endcase
        end
    end

    // hold while converting
    // hold ends on the edge busy rises, and sampling resumes
    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
            hold_r <= 1'b0;
        else
            hold_r <= (state_r == ADC_CONV && cnt_r != '0)
                || conv_begin;
    end

    // capture and retain result at hold
    // taken on the first conversion cycle, kept for any later read
    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
            result_r <= RESET_RESULT;
        else if (state_r == ADC_CONV && cnt_r == CNT_W'(BUSY_LOW_CYC - 1))
            result_r <= sample_in;
    end

    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
            busy_n_r <= 1'b1;
        else
            // rises on the edge the conversion counter runs out
            busy_n_r <= !(state_r == ADC_CONV || conv_begin)
                || (state_r == ADC_CONV && cnt_r == '0);
    end

    // bus enable
    // opens DATA_LEAD_CYC cycles ahead of busy rising
    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
            oe_r <= 1'b0;
        else if (state_r == ADC_CONV)
            oe_r <= cnt_r < CNT_W'(DATA_LEAD_CYC + 1)
                && rc_sync_r[1] && !sel_sync_r[1];
        else
            // outside a conversion the bus follows the two lines
            oe_r <= rc_sync_r[1] && !sel_sync_r[1] && !start_req;
    end

    // coding flag kept in a flop so the port is registered
    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
            fmt_r <= 1'b1;
        else
            fmt_r <= 1'b1;
    end

    assign link.busy_n = busy_n_r;
    assign link.data_o = result_r;
    // all sixteen enables follow the one flop
    assign link.data_oe = {RESULT_W{oe_r}};
    assign twos_complement_format = fmt_r;
endmodule
`default_nettype wire

// ===== rtl/acrp_ctl.sv
// controller end: paces conversions and captures results into a buffer
`timescale 1ns/1ps
`default_nettype none
module acrp_ctl
    import acrp_pkg::*;
(
    input wire logic core_clk, // system clock
    input wire logic resetn, // async reset, active low
    acrp_if.ctl link, // pins toward the converter
    input wire logic start, // request a conversion, taken only while ready; a held level repeats it
    output logic [acrp_pkg::RESULT_W-1:0] res_data, // buffered result
    output logic res_valid, // result available
    input wire logic res_ready, // user takes result
    output logic ready_r // controller can accept start
);
    import acrp_pkg::*;

    acrp_ctl_state_type state_r;
    logic [CNT_W-1:0] cnt_r;
    logic [CNT_W-1:0] space_r;
    logic sel_n_r;
    logic rc_r;
    logic [1:0] busy_sync_r;
    logic busy_prev_r;
    logic busy_rise;
    logic [RESULT_W-1:0] buf_r [2];
    logic [1:0] cnt_buf_r;
    logic rd_ptr_r;
    logic wr_ptr_r;
    logic buf_full;
    logic push;
    logic pop;

    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            busy_sync_r <= 2'b11;
            busy_prev_r <= 1'b1;
        end
        else
        begin
            busy_sync_r <= {busy_sync_r[0], link.busy_n};
            busy_prev_r <= busy_sync_r[1];
        end
    end
    assign busy_rise = !busy_prev_r && busy_sync_r[1];
    assign buf_full = cnt_buf_r == 2'd2;
    assign push = busy_rise && state_r == CTL_WAIT;
    assign pop = res_valid && res_ready;

    // start sequencer; a full buffer stalls new starts
    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            state_r <= CTL_IDLE;
            cnt_r <= '0;
            sel_n_r <= 1'b1;
            rc_r <= 1'b1;
        end
        else
        begin
            case (state_r)
                CTL_IDLE:
                    if (start && !buf_full && space_r == '0)
                    begin
                        rc_r <= 1'b0;
                        cnt_r <= CNT_W'(RC_SETUP_CYC);
                        state_r <= CTL_SETUP;
                    end
                CTL_SETUP:
                    if (cnt_r == '0)
                    begin
                        sel_n_r <= 1'b0;
                        cnt_r <= CNT_W'(RELEASE_CYC / 2);
                        state_r <= CTL_START;
                    end
                    else
                        cnt_r <= cnt_r - 1'b1;
                CTL_START:
                    if (cnt_r == '0)
                    begin
                        rc_r <= 1'b1;
                        state_r <= CTL_WAIT;
                    end
                    else
                        cnt_r <= cnt_r - 1'b1;
                CTL_WAIT:
                    // lines held steady until busy rises
                    if (busy_rise)
                    begin
                        sel_n_r <= 1'b1;
                        state_r <= CTL_IDLE;
                    end
                default:
                    state_r <= CTL_IDLE;
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
            space_r <= '0;
        else if (state_r == CTL_IDLE && start && !buf_full && space_r == '0)
            space_r <= CNT_W'(SPACING_CYC - 1);
        else if (space_r != '0)
            space_r <= space_r - 1'b1;
    end

    // two-entry result buffer
    always_ff @(posedge core_clk)
    begin
        if (push && !buf_full)
            buf_r[wr_ptr_r] <= link.data_bus;
    end

    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            wr_ptr_r <= 1'b0;
            rd_ptr_r <= 1'b0;
            cnt_buf_r <= 2'd0;
        end
        else
        begin
            if (push && !buf_full)
                wr_ptr_r <= !wr_ptr_r;
            if (pop)
                rd_ptr_r <= !rd_ptr_r;
            cnt_buf_r <= cnt_buf_r + 2'(push && !buf_full) - 2'(pop);
        end
    end

    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            res_valid <= 1'b0;
            res_data <= '0;
            ready_r <= 1'b0;
        end
        else
        begin
            res_valid <= (cnt_buf_r - 2'(pop) + 2'(push && !buf_full)) != 2'd0;
            res_data <= (cnt_buf_r - 2'(pop)) == 2'd0
                ? link.data_bus : buf_r[rd_ptr_r ^ pop];
            ready_r <= state_r == CTL_IDLE && !buf_full && space_r == '0;
        end
    end

    assign link.select_n = sel_n_r;
    assign link.read_conv = rc_r;
endmodule
`default_nettype wire

// ===== verif/acrp_monitor.sv
// concurrent checks on the pins between converter and controller
`timescale 1ns/1ps
`default_nettype none
module acrp_monitor
    import acrp_pkg::*;
(
    input wire logic core_clk, // clock
    input wire logic resetn, // reset, active low
    input wire logic select_n, // select, active low
    input wire logic read_conv, // high read, low convert
    input wire logic busy_n, // low while converting
    input wire logic [15:0] data_o, // result bits
    input wire logic [15:0] data_oe, // bus enables
    input wire logic [15:0] data_bus // resolved bus
);
    logic [11:0] low_r;
    logic [11:0] gap_r;
    default clocking @(posedge core_clk); endclocking
    default disable iff (!resetn);
    // cycles busy has been low, and cycles since the last start
    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            low_r <= 12'h000;
        end
        else
        begin
            low_r <= busy_n ? 12'h000 : low_r + 12'h001;
        end
    end
    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            gap_r <= 12'hfff;
        end
        else if ($fell(busy_n))
        begin
            gap_r <= 12'h001;
        end
        else if (gap_r != 12'hfff)
        begin
            gap_r <= gap_r + 12'h001;
        end
    end
    property p_off_desel;
        select_n [*6] |-> data_oe == 16'h0000;
    endproperty
    a_off_desel: assert property (p_off_desel)
        else $error("bus driven while deselected");
    property p_off_conv;
        !read_conv [*6] |-> data_oe == 16'h0000;
    endproperty
    a_off_conv: assert property (p_off_conv)
        else $error("bus driven in convert mode");
    property p_busy_len;
        $rose(busy_n) |-> low_r == BUSY_LOW_CYC;
    endproperty
    a_busy_len: assert property (p_busy_len)
        else $error("busy low time wrong");
    property p_lead;
        $rose(busy_n) && data_oe == 16'hffff
            |-> $past(data_oe, 5) == 16'hffff && $stable(data_bus);
    endproperty
    a_lead: assert property (p_lead)
        else $error("result not valid ahead of busy rise");
    property p_start_sel;
        $fell(busy_n) |-> !select_n;
    endproperty
    a_start_sel: assert property (p_start_sel)
        else $error("conversion began without select");
    property p_rc_setup;
        $fell(select_n) |-> $past(read_conv, 20) == 1'b0 && !read_conv;
    endproperty
    a_rc_setup: assert property (p_rc_setup)
        else $error("read line not low ahead of select");
    property p_release;
        $fell(busy_n) |-> ##[1:40] (read_conv || select_n);
    endproperty
    a_release: assert property (p_release)
        else $error("lines not raised early in conversion");
    property p_guard;
        $rose(busy_n) |-> ##[0:50] (read_conv || select_n);
    endproperty
    a_guard: assert property (p_guard)
        else $error("lines still low after busy rise");
    property p_spacing;
        $fell(busy_n) |-> gap_r >= SPACING_CYC;
    endproperty
    a_spacing: assert property (p_spacing)
        else $error("starts too close together");
    property p_keep;
        busy_n |-> $stable(data_o);
    endproperty
    a_keep: assert property (p_keep)
        else $error("result changed outside a conversion");
    property p_steady;
        !busy_n && low_r > 12'(RELEASE_CYC)
            |-> $stable(select_n) && $stable(read_conv);
    endproperty
    a_steady: assert property (p_steady)
        else $error("control lines moved late in conversion");
    c_conv: cover property ($rose(busy_n) && data_oe == 16'hffff);
    c_start: cover property ($fell(select_n));
    c_read: cover property ($fell(read_conv));
endmodule
`default_nettype wire

// ===== verif/tb.sv
// self-checking bench: converter and controller face to face
`timescale 1ns/1ps
`default_nettype none
module tb;
    import acrp_pkg::*;
    logic core_clk = 1'b0;
    logic resetn = 1'b0;
    logic start = 1'b0;
    logic res_ready = 1'b0;
    logic ready_r, res_valid, hold_r, fmt_a;
    logic [15:0] res_data;
    logic [15:0] sample_a = 16'h0000;
    logic [15:0] sample_b = 16'h0000;
    int fail_count = 0;
    int checks_done = 0;
    logic [15:0] codes [4] = '{16'h7fff, 16'h0000, 16'hffff, 16'h8000};
    acrp_if link_a ();
    acrp_if link_b ();
    always #2.5 core_clk = ~core_clk;
    acrp_adc acrp_adc_inst (.core_clk, .resetn, .link(link_a),
        .sample_in(sample_a), .hold_r, .twos_complement_format(fmt_a));
    acrp_adc acrp_adc_b_inst (.core_clk, .resetn, .link(link_b),
        .sample_in(sample_b), .hold_r(), .twos_complement_format());
    acrp_ctl acrp_ctl_inst (.core_clk, .resetn, .link(link_a), .start,
        .res_data, .res_valid, .res_ready, .ready_r);
    acrp_monitor acrp_monitor_inst (.core_clk, .resetn,
        .select_n(link_a.select_n), .read_conv(link_a.read_conv),
        .busy_n(link_a.busy_n), .data_o(link_a.data_o),
        .data_oe(link_a.data_oe), .data_bus(link_a.data_bus));
    task automatic check(input string what, input logic [15:0] seen,
        input logic [15:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0)
        begin
            $display("No errors found");
        end
        else
        begin
            $display("Errors were found");
        end
        $finish;
    endtask
    function automatic logic pick(input int k);
        case (k)
            0: return link_a.busy_n;
            1: return link_b.busy_n;
            2: return ready_r;
            default: return res_valid;
        endcase
    endfunction
    // bounded wait at falling edges for a flag to reach lvl
    task automatic wait_for(input int k, input logic lvl);
        int n;
        n = 0;
        while (pick(k) !== lvl && n < 3000)
        begin
            @(negedge core_clk);
            n++;
        end
        if (n == 3000)
        begin
            fail_count++;
            end_of_test();
        end
    endtask
    task automatic convert(input logic [15:0] code);
        sample_a = code;
        wait_for(2, 1'b1);
        start = 1'b1;
        @(negedge core_clk);
        start = 1'b0;
        wait_for(0, 1'b0);
        check("hold", {15'h0, hold_r}, 16'h0001);
        wait_for(0, 1'b1);
        repeat (4) @(negedge core_clk);
        check("sample", {15'h0, hold_r}, 16'h0000);
    endtask
    task automatic take(input logic [15:0] exp);
        wait_for(3, 1'b1);
        check("result", res_data, exp);
        res_ready = 1'b1;
        @(negedge core_clk);
        res_ready = 1'b0;
        @(negedge core_clk);
    endtask
    // tb acts as controller of the second converter
    task automatic pins(input logic s, input logic r, input int gap);
        link_b.select_n = s;
        link_b.read_conv = r;
        repeat (gap) @(negedge core_clk);
    endtask
    initial
    begin
        link_b.select_n = 1'b1;
        link_b.read_conv = 1'b1;
        repeat (5) @(negedge core_clk);
        resetn = 1'b1;
        repeat (3) @(negedge core_clk);
        check("format", {15'h0, fmt_a}, 16'h0001);
        convert(codes[0]);
        convert(codes[1]);
        repeat (100) @(negedge core_clk);
        check("ready when full", {15'h0, ready_r}, 16'h0000);
        take(codes[0]);
        take(codes[1]);
        for (int i = 2; i < 4; i++)
        begin
            convert(codes[i]);
            take(codes[i]);
        end
        check("empty", {15'h0, res_valid}, 16'h0000);
        sample_b = 16'h8001;
        pins(1'b1, 1'b0, 20);
        pins(1'b0, 1'b0, 1);
        wait_for(1, 1'b0);
        pins(1'b1, 1'b0, 1);
        // a second start edge while busy must be dropped
        pins(1'b0, 1'b0, 2);
        pins(1'b1, 1'b0, 1);
        wait_for(1, 1'b1);
        repeat (60) @(negedge core_clk);
        check("no queued start", {15'h0, link_b.busy_n}, 16'h0001);
        check("bus off", link_b.data_oe, 16'h0000);
        pins(1'b0, 1'b1, 8);
        check("late read", link_b.data_bus, 16'h8001);
        pins(1'b1, 1'b1, 8);
        check("deselect", link_b.data_oe, 16'h0000);
        pins(1'b1, 1'b0, 20);
        pins(1'b0, 1'b0, 1);
        wait_for(1, 1'b0);
        wait_for(1, 1'b1);
        sample_b = 16'h4321;
        repeat (70) @(negedge core_clk);
        check("restart", {15'h0, link_b.busy_n}, 16'h0000);
        pins(1'b1, 1'b1, 1);
        wait_for(1, 1'b1);
        pins(1'b0, 1'b1, 8);
        check("restart result", link_b.data_bus, 16'h4321);
        pins(1'b0, 1'b0, 10);
        check("select first", {15'h0, link_b.busy_n}, 16'h0000);
        pins(1'b1, 1'b1, 1);
        wait_for(1, 1'b1);
        end_of_test();
    end
endmodule
`default_nettype wire
